// ### inc/pti_pkg.sv
// Purpose: Shared constants and types of the bus target interface
// Assumes: 32-bit multiplexed address/data bus
// Notes: Command codes are those carried on the command lines
package pti_pkg;

   // ----------------------------------------
   // Bus widths
   // ----------------------------------------
   localparam int AD_W = 32;
   localparam int BE_W = 4;
   localparam int WA_W = 30;

   // ----------------------------------------
   // Bus commands
   // ----------------------------------------
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_CFG_RD = 4'hA;
   localparam logic [3:0] CMD_CFG_WR = 4'hB;
   localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC;
   localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
   localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;
   localparam logic [1:0] CFG_TYPE0 = 2'h0;

   // ----------------------------------------
   // Write buffer entry layout
   // ----------------------------------------
   localparam int ENT_DATA_LSB = 0;
   localparam int ENT_BE_LSB = 32;
   localparam int ENT_ADDR_LSB = 36;
   localparam int ENT_CFG_BIT = 66;
   localparam int ENT_W = 67;
   localparam int BUF_DEPTH = 2;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [31:0] RST_AD = 32'h00000000;
   localparam logic [29:0] RST_ADDR = 30'h00000000;
   localparam logic [29:0] ADDR_STEP = 30'h00000001;

   // ----------------------------------------
   // Target states
   // ----------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_BUSY = 5'h02,
      ST_WDATA = 5'h04,
      ST_RDATA = 5'h08,
      ST_TURN = 5'h10
   } pti_state_t;

endpackage : pti_pkg

// ### src/pti_parity.sv
// Purpose: Even parity over address/data and command lines
// Assumes: Purely combinational
// Notes: Output makes the 37-bit group even
`timescale 1ns/1ps
module pti_parity (
   input wire logic [31:0] i_ad,
   input wire logic [3:0] i_cbe,
   output logic o_par
);

   // ----------------------------------------
   // Parity tree
   // ----------------------------------------
   assign o_par = ^{i_ad, i_cbe};

endmodule : pti_parity

// ### src/pti_buf.sv
// Purpose: Small valid/ready buffer for completed write phases
// Assumes: Push only while ready
// Notes: Count reported so the caller can plan ahead
`timescale 1ns/1ps
module pti_buf #(
   parameter int W = pti_pkg::ENT_W,
   parameter int DEPTH = pti_pkg::BUF_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [W-1:0] i_data,
   output logic o_valid,
   input wire logic i_ready,
   output logic [W-1:0] o_data,
   output logic [$clog2(DEPTH):0] o_count
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   wire push = i_valid && o_ready;
   wire pop = o_valid && i_ready;
   wire [PW-1:0] wr_inc = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
   wire [PW-1:0] rd_inc = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

   // ----------------------------------------
   // Flags and read port
   // ----------------------------------------
   assign o_ready = (o_count != ($clog2(DEPTH) + 1)'(DEPTH));
   assign o_valid = (o_count != '0);
   assign o_data = mem[rd_ptr];

   // ----------------------------------------
   // Storage and pointers
   // ----------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= i_data;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         o_count <= '0;
      end
      else
      begin
         wr_ptr <= push ? wr_inc : wr_ptr;
         rd_ptr <= pop ? rd_inc : rd_ptr;
         o_count <= o_count + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
      end
   end

endmodule : pti_buf

// ### src/pti_target.sv
// Purpose: Target side of a 32-bit multiplexed expansion bus
// Assumes: Bus inputs synchronous to I_REF_CLK
// Notes: Writes land in a small buffer; reads fetch one word per phase
//
// What this block does
// - Address and data share one 32-line bus, address first then data phases.
// - Command lines carry the bus command during the address phase.
// - Command lines act as byte enables for write data phases, taken as each phase completes; reads ignore them.
// - Claimed target drives target ready when it can complete the phase.
// - Target can assert stop to ask the master to end.
// - Locked memory target serves only the lock owner meanwhile.
// - Configuration cycles answered only while the select input is high.
// - Device select driven on own decode; input shows any claim.
// - Bus inputs sampled on the rising clock edge.
// - Reset clears all state except the write buffer storage and releases the driven lines.
// - Even parity over address/data and command lines, checked and driven.
`timescale 1ns/1ps
module pti_target #(
   parameter logic [31:0] BAR_BASE = 32'h80000000,
   parameter logic [31:0] BAR_MASK = 32'hFFFFF000
) (
   input wire logic I_REF_CLK,
   input wire logic I_RST_N,
   input wire logic [31:0] I_AD,
   output logic [31:0] O_AD,
   output logic O_AD_OE,
   input wire logic [3:0] I_CBE_N,
   input wire logic I_FRAME_N,
   input wire logic I_IRDY_N,
   output logic O_TRDY_N,
   output logic O_TRDY_OE,
   output logic O_STOP_N,
   output logic O_STOP_OE,
   input wire logic I_DEVSEL_N,
   output logic O_DEVSEL_N,
   output logic O_DEVSEL_OE,
   input wire logic I_LOCK_N,
   input wire logic I_IDSEL,
   input wire logic I_PAR,
   output logic O_PAR,
   output logic O_PAR_OE,
   output logic O_PAR_ERR,
   output logic O_BUS_CLAIMED,
   output logic O_LOCKED,
   input wire logic I_STOP_REQ,
   output logic O_WR_VALID,
   input wire logic I_WR_READY,
   output logic O_WR_CFG,
   output logic [29:0] O_WR_ADDR,
   output logic [3:0] O_WR_BE,
   output logic [31:0] O_WR_DATA,
   output logic O_RD_READY,
   input wire logic I_RD_VALID,
   input wire logic [31:0] I_RD_DATA,
   output logic O_RD_CFG,
   output logic [29:0] O_RD_ADDR
);

   // ----------------------------------------
   // State and registers
   // ----------------------------------------
   pti_pkg::pti_state_t st;
   pti_pkg::pti_state_t next_st;
   logic trdy;
   logic stop;
   logic devsel;
   logic frame_q;
   logic [29:0] addr;
   logic cfg;
   logic lock_addr;
   logic lock_held;
   logic chk_arm;
   logic chk_exp;
   logic [1:0] buf_cnt;
   logic [pti_pkg::ENT_W-1:0] buf_out;
   logic buf_in_ready;
   logic par_in;
   logic par_out;

   // ----------------------------------------
   // Address phase decode
   // ----------------------------------------
   wire [3:0] cmd = I_CBE_N;
   wire addr_phase = !I_FRAME_N && frame_q && (st == pti_pkg::ST_IDLE || st == pti_pkg::ST_TURN);
   wire is_wr = cmd[0];
   wire is_cfg = (cmd == pti_pkg::CMD_CFG_RD) || (cmd == pti_pkg::CMD_CFG_WR);
   wire is_mem = (cmd == pti_pkg::CMD_MEM_RD) || (cmd == pti_pkg::CMD_MEM_WR)
      || (cmd == pti_pkg::CMD_MEM_RD_MULT) || (cmd == pti_pkg::CMD_MEM_RD_LINE)
      || (cmd == pti_pkg::CMD_MEM_WR_INV);
   wire mem_hit = is_mem && ((I_AD & BAR_MASK) == (BAR_BASE & BAR_MASK));
   wire cfg_hit = is_cfg && I_IDSEL && (I_AD[1:0] == pti_pkg::CFG_TYPE0);
   wire hit = addr_phase && (mem_hit || cfg_hit);
   wire lock_reject = lock_held && !I_LOCK_N && mem_hit;

   // ----------------------------------------
   // Data phase status
   // ----------------------------------------
   wire in_data = (st == pti_pkg::ST_WDATA) || (st == pti_pkg::ST_RDATA);
   wire done = in_data && !I_IRDY_N && trdy;
   wire last_done = in_data && !I_IRDY_N && I_FRAME_N && (trdy || stop);
   wire wr_push = (st == pti_pkg::ST_WDATA) && done;
   wire wr_pop = O_WR_VALID && I_WR_READY;
   wire [2:0] cnt_next = {1'b0, buf_cnt} + {2'b00, wr_push} - {2'b00, wr_pop};
   wire wr_room = (cnt_next < 3'(pti_pkg::BUF_DEPTH));
   wire rd_take = O_RD_READY && I_RD_VALID;
   wire [pti_pkg::ENT_W-1:0] wr_entry = {cfg, addr, ~I_CBE_N, I_AD};
   wire drive_ctl = in_data || (st == pti_pkg::ST_TURN);

   assign O_RD_READY = (st == pti_pkg::ST_RDATA) && !trdy && !stop && !last_done;
   assign O_RD_ADDR = addr;
   assign O_RD_CFG = cfg;
   assign O_TRDY_N = !trdy;
   assign O_STOP_N = !stop;
   assign O_DEVSEL_N = !devsel;
   assign O_TRDY_OE = drive_ctl;
   assign O_STOP_OE = drive_ctl;
   assign O_DEVSEL_OE = drive_ctl;
   assign O_LOCKED = lock_held;
   assign O_WR_CFG = buf_out[pti_pkg::ENT_CFG_BIT];
   assign O_WR_ADDR = buf_out[pti_pkg::ENT_ADDR_LSB +: 30];
   assign O_WR_BE = buf_out[pti_pkg::ENT_BE_LSB +: 4];
   assign O_WR_DATA = buf_out[pti_pkg::ENT_DATA_LSB +: 32];

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   pti_buf #(
      .W(pti_pkg::ENT_W),
      .DEPTH(pti_pkg::BUF_DEPTH)
   ) u_wbuf (
      .i_clk(I_REF_CLK),
      .i_rst_n(I_RST_N),
      .i_valid(wr_push),
      .o_ready(buf_in_ready),
      .i_data(wr_entry),
      .o_valid(O_WR_VALID),
      .i_ready(I_WR_READY),
      .o_data(buf_out),
      .o_count(buf_cnt)
   );

   pti_parity u_par_in (
      .i_ad(I_AD),
      .i_cbe(I_CBE_N),
      .o_par(par_in)
   );

   pti_parity u_par_out (
      .i_ad(O_AD),
      .i_cbe(I_CBE_N),
      .o_par(par_out)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      next_st = st;
      unique case (st)
         pti_pkg::ST_IDLE, pti_pkg::ST_TURN:
         begin
            if (hit)
            begin
               next_st = is_wr ? pti_pkg::ST_WDATA : pti_pkg::ST_RDATA;
            end
            else if (addr_phase)
            begin
               next_st = pti_pkg::ST_BUSY;
            end
            else
            begin
               next_st = pti_pkg::ST_IDLE;
            end
         end
         pti_pkg::ST_BUSY:
         begin
            if (I_FRAME_N && I_IRDY_N)
            begin
               next_st = pti_pkg::ST_IDLE;
            end
         end
         pti_pkg::ST_WDATA, pti_pkg::ST_RDATA:
         begin
            if (last_done)
            begin
               next_st = pti_pkg::ST_TURN;
            end
         end
         default:
         begin
            next_st = pti_pkg::ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // Handshake outputs
   // ----------------------------------------
   wire wr_trdy = !last_done && !(stop && (done || !trdy)) && !I_STOP_REQ && wr_room;
   wire rd_trdy = !done && (trdy || rd_take);
   wire next_trdy = (st == pti_pkg::ST_WDATA) ? wr_trdy
      : (st == pti_pkg::ST_RDATA) ? rd_trdy : 1'b0;
   wire next_stop = hit ? (lock_reject || I_STOP_REQ)
      : in_data ? (!last_done && (stop || I_STOP_REQ)) : 1'b0;
   wire next_devsel = hit ? 1'b1 : (in_data && !last_done);
   wire next_lock = (I_FRAME_N && I_LOCK_N) ? 1'b0
      : (lock_held || (done && !I_LOCK_N && !cfg && !lock_addr));

   always_ff @(posedge I_REF_CLK)
   begin
      if (!I_RST_N)
      begin
         st <= pti_pkg::ST_IDLE;
         trdy <= 1'b0;
         stop <= 1'b0;
         devsel <= 1'b0;
         frame_q <= 1'b1;
      end
      else
      begin
         st <= next_st;
         trdy <= next_trdy;
         stop <= next_stop;
         devsel <= next_devsel;
         frame_q <= I_FRAME_N;
      end
   end

   // ----------------------------------------
   // Address, lock and read data
   // ----------------------------------------
   always_ff @(posedge I_REF_CLK)
   begin
      if (!I_RST_N)
      begin
         addr <= pti_pkg::RST_ADDR;
         cfg <= 1'b0;
         lock_addr <= 1'b0;
         lock_held <= 1'b0;
         O_AD <= pti_pkg::RST_AD;
         O_AD_OE <= 1'b0;
      end
      else
      begin
         addr <= addr_phase ? I_AD[31:2] : (done ? addr + pti_pkg::ADDR_STEP : addr);
         cfg <= addr_phase ? is_cfg : cfg;
         lock_addr <= addr_phase ? !I_LOCK_N : lock_addr;
         lock_held <= next_lock;
         O_AD <= rd_take ? I_RD_DATA : O_AD;
         O_AD_OE <= (st == pti_pkg::ST_RDATA) && !last_done;
      end
   end

   // ----------------------------------------
   // Parity drive and check
   // ----------------------------------------
   always_ff @(posedge I_REF_CLK)
   begin
      if (!I_RST_N)
      begin
         O_PAR <= 1'b0;
         O_PAR_OE <= 1'b0;
         chk_arm <= 1'b0;
         chk_exp <= 1'b0;
         O_PAR_ERR <= 1'b0;
         O_BUS_CLAIMED <= 1'b0;
      end
      else
      begin
         O_PAR <= par_out;
         O_PAR_OE <= O_AD_OE;
         chk_arm <= addr_phase || wr_push;
         chk_exp <= par_in;
         O_PAR_ERR <= chk_arm && (I_PAR != chk_exp);
         O_BUS_CLAIMED <= !I_DEVSEL_N;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   trdy_needs_devsel_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      !O_TRDY_N |-> O_TRDY_OE && !O_DEVSEL_N)
      else $error("target ready without device select");

   claim_devsel_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      hit |=> O_DEVSEL_OE && !O_DEVSEL_N)
      else $error("own decode not claimed");

   cfg_idsel_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (addr_phase && is_cfg && !I_IDSEL) |=> !O_DEVSEL_OE)
      else $error("configuration cycle claimed without select");

   wr_buffered_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (st == pti_pkg::ST_WDATA && !I_IRDY_N && !O_TRDY_N) |=> O_WR_VALID)
      else $error("completed write phase not buffered");

   stop_release_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (!O_STOP_N && !I_IRDY_N && I_FRAME_N) |=> O_STOP_OE && O_STOP_N ##1 !O_STOP_OE || !O_DEVSEL_N)
      else $error("stop not released after final phase");

   reset_release_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      $rose(I_RST_N) |-> !O_AD_OE && !O_TRDY_OE && !O_STOP_OE && !O_DEVSEL_OE && !O_PAR_OE)
      else $error("lines driven after reset");

   read_parity_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      O_PAR_OE |-> O_PAR == ^{$past(O_AD), $past(I_CBE_N)})
      else $error("read parity wrong");

   lock_retry_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (hit && lock_reject) |=> !O_STOP_N && O_TRDY_N)
      else $error("locked target served another master");

   wr_be_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (st == pti_pkg::ST_WDATA && !I_IRDY_N && !O_TRDY_N && buf_cnt == 2'h0 && !I_WR_READY)
      |=> O_WR_BE == ~$past(I_CBE_N) && O_WR_DATA == $past(I_AD))
      else $error("byte enables not kept with data");

   buf_room_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      wr_push |-> buf_in_ready)
      else $error("write phase completed into a full buffer");

   turn_drive_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (in_data && last_done) |=> O_DEVSEL_N && O_TRDY_N && O_STOP_N)
      else $error("control lines not released after last phase");

endmodule : pti_target

// ### verif/pti_master.sv
// Purpose: Bus master model that runs whole transactions against the target
// Assumes: Drives at the falling edge, samples at the rising edge
// Notes: Undriven AD shows the inverse of its last value; control lines pull up
`timescale 1ns/1ps
module pti_master (
   input wire logic i_clk,
   input wire logic [31:0] i_ad,
   input wire logic i_ad_oe,
   input wire logic i_trdy_n,
   input wire logic i_stop_n,
   input wire logic i_devsel_n,
   input wire logic i_tgt_oe,
   input wire logic i_par,
   input wire logic i_par_oe,
   output logic [31:0] o_ad_w,
   output logic o_par_w,
   output logic o_devsel_w,
   output logic o_frame_n,
   output logic o_irdy_n,
   output logic [3:0] o_cbe_n,
   output logic o_lock_n,
   output logic o_idsel
);
   logic frame_n = 1'b1, irdy_n = 1'b1, lock_n = 1'b1, idsel = 1'b0, ad_oe = 1'b0;
   logic par = 1'b0, par_nx = 1'b0, par_bad = 1'b0;
   logic [3:0] cbe_n = 4'hF;
   logic [31:0] ad = 32'h0, last = 32'h0;
   logic [36:0] prev = 37'h0;
   logic [31:0] wdat [8];
   logic [31:0] rdat [8];
   logic trdy_w, stop_w;
   int got = 0, dev_k = -1, stop_seen = 0, par_n = 0, par_miss = 0;

   // ----------------------------------------
   // Wire levels
   // ----------------------------------------
   assign o_ad_w = i_ad_oe ? i_ad : (ad_oe ? ad : ~last);
   assign o_par_w = i_par_oe ? i_par : par;
   assign o_devsel_w = i_tgt_oe ? i_devsel_n : 1'b1;
   assign trdy_w = i_tgt_oe ? i_trdy_n : 1'b1;
   assign stop_w = i_tgt_oe ? i_stop_n : 1'b1;
   assign {o_frame_n, o_irdy_n, o_cbe_n, o_lock_n, o_idsel} = {frame_n, irdy_n, cbe_n, lock_n, idsel};

   // ----------------------------------------
   // Parity driven and checked
   // ----------------------------------------
   always @(posedge i_clk)
   begin
      if (i_ad_oe || ad_oe)
         last <= o_ad_w;
      if (i_par_oe)
      begin
         par_n++;
         if (i_par !== ^prev)
            par_miss++;
      end
      prev <= {o_ad_w, o_cbe_n};
      par_nx = ^{o_ad_w, o_cbe_n};
   end
   always @(negedge i_clk)
      par = par_nx ^ par_bad;

   // ----------------------------------------
   // Transaction; lk[1] lock at address, lk[0] lock during data
   // ----------------------------------------
   task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input int n, input logic [3:0] be,
                       input logic sel, input logic [1:0] lk);
      int k;
      logic fin, ab;
      {got, dev_k, stop_seen, fin, ab} = {32'h0, -32'sh1, 32'h0, 2'h0};
      @(negedge i_clk);
      frame_n = 1'b0;
      {ad_oe, ad, cbe_n, idsel, lock_n} = {1'b1, addr, cmd, sel, ~lk[1]};
      @(negedge i_clk);
      {idsel, lock_n, irdy_n, cbe_n} = {1'b0, ~lk[0], 1'b0, ~be};
      {ad_oe, ad, frame_n} = {cmd[0], wdat[0], n == 1};
      for (k = 0; k < 40 && !fin; k++)
      begin
         @(posedge i_clk);
         if (dev_k < 0 && !o_devsel_w)
            dev_k = k;
         if (!trdy_w)
         begin
            rdat[got] = o_ad_w;
            got++;
         end
         if (!stop_w)
            stop_seen = 1;
         fin = frame_n && (!trdy_w || !stop_w || ab);
         ab = (k >= 3) && o_devsel_w;
         @(negedge i_clk);
         ad = wdat[got];
         frame_n = frame_n || (got >= n - 1) || (stop_seen != 0) || ab;
      end
      {frame_n, irdy_n, ad_oe, cbe_n} = {3'b110, 4'hF};
   endtask : xfer
endmodule : pti_master

// ### verif/pti_target_bench.sv
// Purpose: Self-checking bench of the bus target
// Assumes: Master model drives the bus, bench plays the user side
// Notes: Inputs change at the falling edge
`timescale 1ns/1ps
module pti_target_bench;
   localparam logic [31:0] BASE = 32'h80000000;
   logic clk = 1'b0, rst_n = 1'b0, stop_req = 1'b0, wr_rdy = 1'b0, rd_vld = 1'b0;
   logic [31:0] rd_dat = 32'h0;
   int errors = 0, n_tests = 0, perr = 0, claim = 0;
   logic [31:0] ad_w, ad, wr_data;
   logic [29:0] wr_addr, rd_addr;
   logic [3:0] cbe_n, wr_be;
   logic ad_oe, trdy_n, trdy_oe, stop_n, stop_oe, devsel_n, devsel_oe, devsel_w, par, par_oe, par_w;
   logic par_err, claimed, locked, wr_valid, wr_cfg, rd_ready, rd_cfg, frame_n, irdy_n, lock_n, idsel;

   pti_target #(.BAR_BASE(BASE), .BAR_MASK(32'hFFFFF000)) u_pti_target (.I_REF_CLK(clk), .I_RST_N(rst_n),
      .I_AD(ad_w), .O_AD(ad), .O_AD_OE(ad_oe), .I_CBE_N(cbe_n), .I_FRAME_N(frame_n), .I_IRDY_N(irdy_n),
      .O_TRDY_N(trdy_n), .O_TRDY_OE(trdy_oe), .O_STOP_N(stop_n), .O_STOP_OE(stop_oe), .I_DEVSEL_N(devsel_w),
      .O_DEVSEL_N(devsel_n), .O_DEVSEL_OE(devsel_oe), .I_LOCK_N(lock_n), .I_IDSEL(idsel), .I_PAR(par_w),
      .O_PAR(par), .O_PAR_OE(par_oe), .O_PAR_ERR(par_err), .O_BUS_CLAIMED(claimed), .O_LOCKED(locked),
      .I_STOP_REQ(stop_req), .O_WR_VALID(wr_valid), .I_WR_READY(wr_rdy), .O_WR_CFG(wr_cfg),
      .O_WR_ADDR(wr_addr), .O_WR_BE(wr_be), .O_WR_DATA(wr_data), .O_RD_READY(rd_ready),
      .I_RD_VALID(rd_vld), .I_RD_DATA(rd_dat), .O_RD_CFG(rd_cfg), .O_RD_ADDR(rd_addr));
   pti_master u_pti_master (.i_clk(clk), .i_ad(ad), .i_ad_oe(ad_oe), .i_trdy_n(trdy_n), .i_stop_n(stop_n),
      .i_devsel_n(devsel_n), .i_tgt_oe(trdy_oe & stop_oe & devsel_oe), .i_par(par), .i_par_oe(par_oe),
      .o_ad_w(ad_w), .o_par_w(par_w), .o_devsel_w(devsel_w), .o_frame_n(frame_n), .o_irdy_n(irdy_n),
      .o_cbe_n(cbe_n), .o_lock_n(lock_n), .o_idsel(idsel));

   // ----------------------------------------
   // Clock, user read answer, monitors
   // ----------------------------------------
   initial
      forever #25 clk = ~clk;
   function automatic logic [31:0] rd_word(input logic [29:0] a, input logic cfg);
      return {a, 2'b00} ^ 32'hC3C30000 ^ {31'h0, cfg};
   endfunction : rd_word
   always @(negedge clk)
   begin
      rd_vld <= rd_ready;
      rd_dat <= rd_word(rd_addr, rd_cfg);
   end
   always @(posedge clk)
   begin
      perr <= perr + (par_err === 1'b1);
      claim <= claim + (claimed === 1'b1);
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic pop(input logic [29:0] a, input logic [3:0] be, input logic [31:0] d, input logic cfg);
      int k;
      for (k = 0; k < 20 && wr_valid !== 1'b1; k++)
         @(negedge clk);
      chk("wr_entry", {2'h0, a}, {2'h0, wr_addr});
      chk("wr_be", {28'h0, be}, {28'h0, wr_be});
      chk("wr_data", d, wr_data);
      chk("wr_cfg", {31'h0, cfg}, {31'h0, wr_cfg});
      wr_rdy = 1'b1;
      @(negedge clk);
      wr_rdy = 1'b0;
      @(negedge clk);
   endtask : pop
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_write(input logic [3:0] cmd, input logic [3:0] be);
      u_pti_master.wdat[0] = 32'hDEAD0000 ^ {24'h0, cmd, be};
      u_pti_master.xfer(cmd, BASE + 32'h10, 1, be, 1'b0, 2'h0);
      chk("devsel_cycle", 32'h0, u_pti_master.dev_k);
      chk("wr_phases", 32'h1, u_pti_master.got);
      pop(30'h20000004, be, 32'hDEAD0000 ^ {24'h0, cmd, be}, 1'b0);
      $display("test write done");
   endtask : t_write
   task automatic t_read(input logic [3:0] cmd);
      u_pti_master.xfer(cmd, BASE + 32'h20, 1, 4'hF, 1'b0, 2'h0);
      chk("rd_data", rd_word(30'h20000008, 1'b0), u_pti_master.rdat[0]);
      $display("test read done");
   endtask : t_read
   task automatic t_burst;
      int i;
      for (i = 0; i < 3; i++)
         u_pti_master.wdat[i] = 32'h11110000 + i;
      fork
         u_pti_master.xfer(pti_pkg::CMD_MEM_WR, BASE + 32'h100, 3, 4'hC, 1'b0, 2'h0);
         begin
            repeat (12) @(negedge clk);
            chk("held_full", 32'h1, {31'h0, u_pti_master.got inside {1, 2}});
            for (i = 0; i < 3; i++)
               pop(30'h20000040 + 30'(i), 4'hC, 32'h11110000 + i, 1'b0);
         end
      join
      chk("burst_phases", 32'h3, u_pti_master.got);
      $display("test burst done");
   endtask : t_burst
   task automatic t_cfg;
      u_pti_master.wdat[0] = 32'h0000CAFE;
      u_pti_master.xfer(pti_pkg::CMD_CFG_WR, 32'h8, 1, 4'hF, 1'b0, 2'h0);
      chk("cfg_unsel", 32'hFFFFFFFF, u_pti_master.dev_k);
      chk("cfg_no_entry", 32'h0, {31'h0, wr_valid});
      u_pti_master.xfer(pti_pkg::CMD_CFG_WR, 32'h8, 1, 4'hF, 1'b1, 2'h0);
      pop(30'h2, 4'hF, 32'h0000CAFE, 1'b1);
      u_pti_master.xfer(pti_pkg::CMD_CFG_RD, 32'hC, 1, 4'hF, 1'b1, 2'h0);
      chk("cfg_rd", rd_word(30'h3, 1'b1), u_pti_master.rdat[0]);
      u_pti_master.xfer(pti_pkg::CMD_MEM_RD, 32'h40000000, 1, 4'hF, 1'b0, 2'h0);
      chk("miss_unclaimed", 32'hFFFFFFFF, u_pti_master.dev_k);
      $display("test select done");
   endtask : t_cfg
   task automatic t_stop_lock;
      stop_req = 1'b1;
      u_pti_master.xfer(pti_pkg::CMD_MEM_RD, BASE, 1, 4'hF, 1'b0, 2'h0);
      stop_req = 1'b0;
      chk("stop_retry", 32'h1, u_pti_master.stop_seen + 32'(u_pti_master.got));
      u_pti_master.xfer(pti_pkg::CMD_MEM_WR, BASE, 1, 4'hF, 1'b0, 2'h1);
      pop(30'h20000000, 4'hF, u_pti_master.wdat[0], 1'b0);
      chk("locked", 32'h1, {31'h0, locked});
      u_pti_master.xfer(pti_pkg::CMD_MEM_RD, BASE, 1, 4'hF, 1'b0, 2'h3);
      chk("lock_retry", 32'h1, u_pti_master.stop_seen + 32'(u_pti_master.got));
      u_pti_master.xfer(pti_pkg::CMD_MEM_RD, BASE, 1, 4'hF, 1'b0, 2'h0);
      chk("owner_served", 32'h1, u_pti_master.got);
      chk("unlocked", 32'h0, {31'h0, locked});
      $display("test stop and lock done");
   endtask : t_stop_lock
   task automatic t_parity;
      int p0;
      p0 = perr;
      u_pti_master.par_bad = 1'b1;
      t_write(pti_pkg::CMD_MEM_WR, 4'hF);
      u_pti_master.par_bad = 1'b0;
      chk("par_err_pulses", 32'h2, perr - p0);
      chk("rd_par_miss", 32'h0, u_pti_master.par_miss);
      chk("rd_par_seen", 32'h1, {31'h0, u_pti_master.par_n > 0});
      $display("test parity done");
   endtask : t_parity

   initial
   begin
      repeat (20) @(negedge clk);
      chk("idle_oe", 32'h0, {23'h0, ad_oe, trdy_oe, stop_oe, devsel_oe, par_oe, par_err, wr_valid, rd_ready, locked});
      chk("idle_high", 32'h7, {29'h0, trdy_n, stop_n, devsel_n});
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      t_write(pti_pkg::CMD_MEM_WR, 4'h5);
      t_write(pti_pkg::CMD_MEM_WR_INV, 4'hA);
      t_read(pti_pkg::CMD_MEM_RD);
      t_read(pti_pkg::CMD_MEM_RD_MULT);
      t_read(pti_pkg::CMD_MEM_RD_LINE);
      t_burst;
      t_cfg;
      t_stop_lock;
      t_parity;
      chk("claim_seen", 32'h1, {31'h0, claim > 0});
      finish_test;
   end
   initial
   begin
      repeat (4000) @(posedge clk);
      errors++;
      finish_test;
   end
endmodule : pti_target_bench
